// file: logic/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
  // byte map
  localparam int TIME_BYTES = 10;
  localparam int RAM_BYTES = 114;
  localparam int CTL_BYTES = 4;
  localparam logic [6:0] ADDR_SEC = 7'h00;
  localparam logic [6:0] ADDR_SEC_AL = 7'h01;
  localparam logic [6:0] ADDR_MIN = 7'h02;
  localparam logic [6:0] ADDR_MIN_AL = 7'h03;
  localparam logic [6:0] ADDR_HR = 7'h04;
  localparam logic [6:0] ADDR_HR_AL = 7'h05;
  localparam logic [6:0] ADDR_WDAY = 7'h06;
  localparam logic [6:0] ADDR_MDAY = 7'h07;
  localparam logic [6:0] ADDR_MON = 7'h08;
  localparam logic [6:0] ADDR_YEAR = 7'h09;
  localparam logic [6:0] ADDR_A = 7'h0A;
  localparam logic [6:0] ADDR_B = 7'h0B;
  localparam logic [6:0] ADDR_C = 7'h0C;
  localparam logic [6:0] ADDR_D = 7'h0D;
  localparam logic [6:0] ADDR_RAM = 7'h0E;
  // register a fields
  localparam int A_UIP = 7;
  localparam logic [2:0] OSC_RUN = 3'h2;
  localparam logic [1:0] OSC_HOLD = 2'h3;
  // register b fields
  localparam int B_FREEZE = 7;
  localparam int B_PIE = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_SQUARE_WAVE_EN = 3;
  localparam int B_BIN = 2;
  localparam int B_H24 = 1;
  // register c fields
  localparam int C_IRQ = 7;
  // reset and fixed values
  localparam logic [6:0] A_RESET = 7'h20;
  localparam logic [7:0] B_RESET = 8'h02;
  localparam logic [7:0] D_VALUE = 8'h00;
  localparam logic [1:0] DONT_CARE = 2'h3;
  localparam int HOUR_PM = 7;
  // pins at rest: ad, as, ds_n, rw_n, ce_n
  localparam logic [11:0] PIN_IDLE = 12'h007;
  // time base
  localparam int BASE_HZ = 32768;
  localparam int CHAIN_W = 15;
  localparam logic [14:0] CHAIN_HALF = 15'h4000;
  localparam logic [14:0] CHAIN_LAST = 15'h7FFF;
  localparam logic [3:0] RATE1_SHIFT = 4'h7;
  localparam logic [3:0] RATE2_SHIFT = 4'h8;
  localparam int PRE_UPDATE_US = 244;
  localparam int PRE_TICKS =
    (PRE_UPDATE_US * BASE_HZ + 999999) / 1000000;
endpackage
`default_nettype wire

// file: logic/pins_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pins_if;
  logic [7:0] ad; // filtered address/data lines
  logic as_s; // address strobe
  logic ds_n; // data strobe, low reads
  logic rw_n; // write strobe, low writes
  logic ce_n; // chip enable
  modport src(output ad, as_s, ds_n, rw_n, ce_n);
  modport dst(input ad, as_s, ds_n, rw_n, ce_n);
endinterface
`default_nettype wire

// file: logic/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // raw pins: ad, as, ds_n, rw_n, ce_n
  input wire logic [11:0] raw,
  // filtered pins
  pins_if.src pins
);
  typedef struct packed {
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] s3;
    logic [11:0] filt;
  } sync_type;
  sync_type q;
  sync_type d;
  logic [11:0] diff;

  // a bit only moves once stages two and three agree
  assign diff = q.s2 ^ q.s3;

  // three-stage chain plus agreement filter
  always_comb
  begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = (q.s3 & ~diff) | (q.filt & diff);
  end

  // idle pin levels on reset so no false edges appear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      q <= {4{rtc_pkg::PIN_IDLE}};
    else
      q <= d;
  end

  assign {pins.ad, pins.as_s, pins.ds_n, pins.rw_n, pins.ce_n} = q.filt;
endmodule
`default_nettype wire

// file: logic/count_step.sv
`timescale 1ns/1ps
`default_nettype none
module count_step (
  // count and its limits, limits given in binary
  input wire logic [7:0] value,
  input wire logic [7:0] first,
  input wire logic [7:0] last,
  input wire logic bin,
  // advanced count and wrap indication
  output logic [7:0] nxt,
  output logic wrap
);
  logic [7:0] first_f;
  logic [7:0] last_f;

  // limits follow the selected number format
  assign first_f = bin ? first : {4'(first / 8'h0A), 4'(first % 8'h0A)};
  assign last_f = bin ? last : {4'(last / 8'h0A), 4'(last % 8'h0A)};
  assign wrap = value == last_f;

  // bcd carries from the low digit at nine
  always_comb
  begin
    if (wrap)
      nxt = first_f;
    else if (!bin && value[3:0] == 4'h9)
      nxt = {value[7:4] + 4'h1, 4'h0};
    else
      nxt = value + 8'h01;
  end
endmodule
`default_nettype wire

// file: logic/rtc_core.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_core #(
  parameter int REF_HZ = 20000000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // multiplexed address/data bus
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe_n,
  // bus strobes
  input wire logic as_in,
  input wire logic ds_n_in,
  input wire logic rw_n_in,
  input wire logic ce_n_in,
  // open-drain interrupt request
  output logic irq_n_out,
  output logic irq_oe_n
);
  localparam int ACC_W = $clog2(REF_HZ) + 1;

  // the fractional divider needs at least two clocks per base tick
  if (REF_HZ < 2 * rtc_pkg::BASE_HZ)
  begin : g_chk
    $error("ref clock too slow for the time base");
  end

  typedef struct packed {
    logic [9:0][7:0] user; // host-visible copy
    logic [9:0][7:0] core; // internal counting copy
    logic [113:0][7:0] ram; // general bytes
    logic [6:0] ctl_a; // oscillator and rate field
    logic [7:0] ctl_b; // configuration
    logic [2:0] flags; // periodic, alarm, update done
    logic [2:0] pend; // events held during a c read
    logic [7:0] c_snap; // c value latched at read start
    logic rd_c; // c read in progress
    logic [6:0] addr; // latched address
    logic [7:0] dout; // read data
    logic [2:0] prev; // last as, ds_n, rw_n
    logic [ACC_W-1:0] acc; // base tick phase
    logic [14:0] chain; // divider chain
  } state_type;

  localparam state_type RESET_STATE = '{
    ctl_a: rtc_pkg::A_RESET,
    ctl_b: rtc_pkg::B_RESET,
    prev: 3'h3,
    chain: rtc_pkg::CHAIN_HALF,
    default: '0
  };

  state_type q;
  state_type d;
  pins_if pins();

  // pins cross into the clock domain here
  pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw({ad_in, as_in, ds_n_in, rw_n_in, ce_n_in}),
    .pins(pins)
  );

  // periodic tap mask for the rate field
  function automatic logic [14:0] rate_mask(input logic [3:0] rs);
    logic [3:0] k;
    begin
      if (rs == 4'h1)
        k = rtc_pkg::RATE1_SHIFT;
      else if (rs == 4'h2)
        k = rtc_pkg::RATE2_SHIFT;
      else
        k = rs - 4'h1;
      return (15'h0001 << k) - 15'h0001;
    end
  endfunction

  // stored count to binary for the calendar limits
  function automatic logic [7:0] to_bin(input logic [7:0] v,
                                        input logic bin);
    return bin ? v : ({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]};
  endfunction

  // alarm byte compare with the don't-care code
  function automatic logic hit(input logic [7:0] al,
                               input logic [7:0] t);
    return al[7:6] == rtc_pkg::DONT_CARE || al == t;
  endfunction

  // configuration views
  logic bin;
  logic h24;
  logic freeze;
  logic run;
  assign bin = q.ctl_b[rtc_pkg::B_BIN];
  assign h24 = q.ctl_b[rtc_pkg::B_H24];
  assign freeze = q.ctl_b[rtc_pkg::B_FREEZE];
  assign run = q.ctl_a[6:4] == rtc_pkg::OSC_RUN;

  // base tick from a phase accumulator
  logic [ACC_W-1:0] acc_sum;
  logic tick;
  assign acc_sum = q.acc + ACC_W'(rtc_pkg::BASE_HZ);
  assign tick = acc_sum >= ACC_W'(REF_HZ);

  // second boundary and pending window
  logic [14:0] chain_n;
  logic upd;
  logic update_pending;
  logic per_ev;
  assign chain_n = q.chain + 15'h0001;
  assign upd = run && tick && q.chain == rtc_pkg::CHAIN_LAST;
  // pending is raised the last ticks before the wrap
  assign update_pending = run && !freeze &&
    q.chain > rtc_pkg::CHAIN_LAST - 15'(rtc_pkg::PRE_TICKS);
  // periodic event on the chosen chain tap
  assign per_ev = run && tick && q.ctl_a[3:0] != 4'h0 &&
    (chain_n & rate_mask(q.ctl_a[3:0])) == 15'h0000;

  // calendar limits from the current month and year
  logic [7:0] mon_b;
  logic [7:0] yr_b;
  logic [7:0] dim;
  assign mon_b = to_bin(q.core[8], bin);
  assign yr_b = to_bin(q.core[9], bin);

  // days in month, leap year every fourth year
  always_comb
  begin
    unique case (mon_b)
      8'h02: dim = (yr_b[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: dim = 8'h1E;
      default: dim = 8'h1F;
    endcase
  end

  // one stepping unit per counted field
  logic [7:0] sec_n, min_n, hr_s, wd_n, day_n, mon_n, yr_n;
  logic sec_c, min_c, hr_c, wd_c, day_c, mon_c, yr_c;
  logic [7:0] hr_v;
  assign hr_v = h24 ? q.core[4] : {1'b0, q.core[4][6:0]};

  count_step u_sec (
    .value(q.core[0]), .first(8'h00), .last(8'h3B), .bin(bin),
    .nxt(sec_n), .wrap(sec_c)
  );
  count_step u_min (
    .value(q.core[2]), .first(8'h00), .last(8'h3B), .bin(bin),
    .nxt(min_n), .wrap(min_c)
  );
  count_step u_hr (
    .value(hr_v), .first(h24 ? 8'h00 : 8'h01),
    .last(h24 ? 8'h17 : 8'h0C), .bin(bin),
    .nxt(hr_s), .wrap(hr_c)
  );
  count_step u_wd (
    .value(q.core[6]), .first(8'h01), .last(8'h07), .bin(bin),
    .nxt(wd_n), .wrap(wd_c)
  );
  count_step u_day (
    .value(q.core[7]), .first(8'h01), .last(dim), .bin(bin),
    .nxt(day_n), .wrap(day_c)
  );
  count_step u_mon (
    .value(q.core[8]), .first(8'h01), .last(8'h0C), .bin(bin),
    .nxt(mon_n), .wrap(mon_c)
  );
  count_step u_yr (
    .value(q.core[9]), .first(8'h00), .last(8'h63), .bin(bin),
    .nxt(yr_n), .wrap(yr_c)
  );

  // hour rollover; 12-hour mode flips pm going 11 to 12
  logic pm_flip;
  logic day_roll;
  logic [7:0] hr_n;
  assign pm_flip = !h24 && hr_s[6:0] == (bin ? 7'h0C : 7'h12);
  assign day_roll = h24 ? hr_c :
    pm_flip && q.core[4][rtc_pkg::HOUR_PM];
  assign hr_n = h24 ? hr_s :
    {q.core[4][rtc_pkg::HOUR_PM] ^ pm_flip, hr_s[6:0]};

  // advanced copy of the ten bytes, alarm bytes untouched
  logic [9:0][7:0] adv;
  always_comb
  begin
    adv = q.core;
    adv[0] = sec_n;
    if (sec_c)
    begin
      adv[2] = min_n;
      if (min_c)
      begin
        adv[4] = hr_n;
        if (day_roll)
        begin
          adv[6] = wd_n;
          adv[7] = day_n;
          if (day_c)
          begin
            adv[8] = mon_n;
            if (mon_c)
              adv[9] = yr_n;
          end
        end
      end
    end
  end

  // alarm compares the advanced time with the alarm bytes
  logic al_ev;
  assign al_ev = upd && hit(q.core[1], adv[0]) &&
    hit(q.core[3], adv[2]) && hit(q.core[5], adv[4]);

  // events: periodic, alarm, update done
  logic [2:0] ev;
  assign ev = {per_ev, al_ev, upd};

  // interrupt condition; update source also needs no freeze
  logic irq_act;
  logic [2:0] en;
  assign en = {q.ctl_b[rtc_pkg::B_PIE], q.ctl_b[rtc_pkg::B_AIE],
    q.ctl_b[rtc_pkg::B_UIE] && !freeze};
  assign irq_act = |(q.flags & en);

  // bus edges from the filtered pins
  logic sel;
  logic as_fall;
  logic ds_fall;
  logic ds_rise;
  logic wr_end;
  assign sel = !pins.ce_n;
  assign as_fall = q.prev[2] && !pins.as_s;
  assign ds_fall = !q.prev[1] ? 1'b0 : !pins.ds_n;
  assign ds_rise = !q.prev[1] && pins.ds_n;
  // data is taken as the write strobe ends
  assign wr_end = !q.prev[0] && pins.rw_n && sel;

  logic rd_start;
  logic rd_end;
  assign rd_start = ds_fall && sel && q.addr == rtc_pkg::ADDR_C;
  assign rd_end = q.rd_c && ds_rise;

  // register c value: irq summary, flags, low bits zero
  logic [7:0] c_val;
  assign c_val = {irq_act, q.flags, 4'h0};

  // read mux over the byte map
  logic [7:0] rdata;
  logic [6:0] ram_ix;
  assign ram_ix = q.addr - rtc_pkg::ADDR_RAM;
  always_comb
  begin
    if (q.addr < rtc_pkg::ADDR_A)
      rdata = q.user[q.addr[3:0]];
    else if (q.addr == rtc_pkg::ADDR_A)
      rdata = {update_pending, q.ctl_a};
    else if (q.addr == rtc_pkg::ADDR_B)
      rdata = q.ctl_b;
    else if (q.addr == rtc_pkg::ADDR_C)
      rdata = q.rd_c ? q.c_snap : c_val;
    else if (q.addr == rtc_pkg::ADDR_D)
      rdata = rtc_pkg::D_VALUE;
    else
      rdata = q.ram[ram_ix];
  end

  // next state
  always_comb
  begin
    d = q;
    d.prev = {pins.as_s, pins.ds_n, pins.rw_n};
    d.dout = rdata;
    // base tick phase
    d.acc = tick ? acc_sum - ACC_W'(REF_HZ) : acc_sum;
    // chain parks at half so the first wrap is half a second out
    if (!run)
      d.chain = rtc_pkg::CHAIN_HALF;
    else if (tick)
      d.chain = chain_n;
    // the core always counts; the host copy only without freeze
    if (upd)
    begin
      d.core = adv;
      if (!freeze)
        d.user = adv;
    end
    // address phase
    if (as_fall)
      d.addr = pins.ad[6:0];
    // host writes land in both copies and win over an update
    if (wr_end)
    begin
      if (q.addr < rtc_pkg::ADDR_A)
      begin
        d.user[q.addr[3:0]] = pins.ad;
        d.core[q.addr[3:0]] = pins.ad;
      end
      else if (q.addr == rtc_pkg::ADDR_A)
        d.ctl_a = pins.ad[6:0];
      else if (q.addr == rtc_pkg::ADDR_B)
      begin
        d.ctl_b = pins.ad;
        // freeze going high drops the update enable
        if (pins.ad[rtc_pkg::B_FREEZE] && !freeze)
          d.ctl_b[rtc_pkg::B_UIE] = 1'b0;
      end
      else if (q.addr >= rtc_pkg::ADDR_RAM)
        d.ram[ram_ix] = pins.ad;
      // c and d take no writes
    end
    // flags; a c read clears them and parks new events
    if (rd_start)
    begin
      d.c_snap = c_val;
      d.rd_c = 1'b1;
      d.flags = 3'h0;
      d.pend = ev;
    end
    else if (q.rd_c)
    begin
      d.pend = q.pend | ev;
      if (rd_end)
      begin
        d.rd_c = 1'b0;
        d.flags = q.pend | ev;
        d.pend = 3'h0;
      end
    end
    else
      d.flags = q.flags | ev;
  end

  // single state register; reset clears enables and flags
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      q <= RESET_STATE;
    else
      q <= d;
  end

  // bus drives only during a selected read strobe
  assign ad_out = q.dout;
  assign ad_oe_n = !(sel && !pins.ds_n);
  // open drain: line pulled low only while a source is active
  assign irq_n_out = 1'b0;
  assign irq_oe_n = !irq_act;
endmodule
`default_nettype wire

// file: dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host processor on the multiplexed bus; moves only after rising edges
module host_model (
  // clock
  input wire logic ref_clk,
  // bus toward the core
  output logic [7:0] ad_in,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n,
  output logic as_in,
  output logic ds_n_in,
  output logic rw_n_in,
  output logic ce_n_in
);
  logic [7:0] drv_q = 8'h00; // last value the host put on the lines
  logic drv_en = 1'b0; // host owns the lines
  // wire level: host, else core, else inverse of the last host value
  assign ad_in = drv_en ? drv_q : (!ad_oe_n ? ad_out : ~drv_q);
  // strobes at rest from time zero
  initial
  begin
    as_in <= 1'b0;
    ds_n_in <= 1'b1;
    rw_n_in <= 1'b1;
    ce_n_in <= 1'b1;
  end
  // address phase; the core latches on the strobe fall
  task automatic addr_phase(input logic [6:0] a);
    @(posedge ref_clk);
    as_in <= 1'b1;
    drv_en <= 1'b1;
    drv_q <= {1'b0, a};
    repeat (5) @(posedge ref_clk);
    as_in <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  // write one byte; data held five cycles past the strobe rise
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    addr_phase(a);
    drv_q <= d;
    ce_n_in <= 1'b0;
    rw_n_in <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rw_n_in <= 1'b1;
    repeat (5) @(posedge ref_clk);
    ce_n_in <= 1'b1;
    drv_en <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  // read one byte; unknown comes back when the core never drove
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    addr_phase(a);
    drv_en <= 1'b0;
    ce_n_in <= 1'b0;
    ds_n_in <= 1'b0;
    // data has stood for several cycles when taken at this edge
    repeat (8) @(posedge ref_clk);
    d = (ad_oe_n === 1'b0) ? ad_out : 8'hXX;
    ds_n_in <= 1'b1;
    ce_n_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: dv/rtc_core_props.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks; config byte shadowed from host writes
module rtc_core_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus
  input wire logic [7:0] ad_in,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic as_in,
  input wire logic ds_n_in,
  input wire logic rw_n_in,
  input wire logic ce_n_in,
  // interrupt
  input wire logic irq_n_out,
  input wire logic irq_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic as_q; // previous address strobe
  logic rw_q; // previous write strobe
  logic [6:0] addr_q; // address at the strobe fall
  logic [7:0] b_q; // shadow config byte
  logic en_any; // some interrupt enable set
  // shadow follows raw pins, so it leads the core by the filter delay
  always_ff @(posedge ref_clk)
  begin
    as_q <= as_in;
    rw_q <= rw_n_in;
    if (rst)
      b_q <= rtc_pkg::B_RESET;
    else if (!rw_q && rw_n_in && !ce_n_in && addr_q == rtc_pkg::ADDR_B)
    begin
      b_q <= ad_in;
      // freeze rising drops the update enable
      if (ad_in[7] && !b_q[7])
        b_q[4] <= 1'b0;
    end
    if (as_q && !as_in)
      addr_q <= ad_in[6:0];
  end
  assign en_any = |b_q[6:4];
  // read data of address a has settled on the bus
  sequence settled_read(logic [6:0] a);
    !ad_oe_n && !$past(ad_oe_n) && addr_q == a;
  endsequence
  a_reset_quiet: assert property ($fell(rst) |-> irq_oe_n)
    else $error("interrupt pulled after reset");
  a_c_low_zero: assert property (settled_read(rtc_pkg::ADDR_C) |->
    ad_out[3:0] == 4'h0) else $error("status low bits set");
  a_d_zero: assert property (settled_read(rtc_pkg::ADDR_D) |->
    ad_out == rtc_pkg::D_VALUE) else $error("register d not zero");
  a_any_irq_flag_sum: assert property (settled_read(rtc_pkg::ADDR_C) |->
    ad_out[7] == ((ad_out[6] && b_q[6]) || (ad_out[5] && b_q[5])
    || (ad_out[4] && b_q[4] && !b_q[7]))) else $error("summary bit wrong");
  a_irq_enabled: assert property (!irq_oe_n |-> en_any ||
    $past(en_any, 8)) else $error("interrupt with no enable");
  a_c_stable: assert property (settled_read(rtc_pkg::ADDR_C) |=>
    ad_oe_n || $stable(ad_out)) else $error("status moved in read");
  a_uip_frozen: assert property (settled_read(rtc_pkg::ADDR_A)
    ##0 b_q[7] |-> !ad_out[7]) else $error("pending while frozen");
  a_c_read_quiet: assert property (settled_read(rtc_pkg::ADDR_C)
    |-> irq_oe_n) else $error("interrupt during status read");
  c_irq: cover property ($fell(irq_oe_n));
  c_status: cover property (settled_read(rtc_pkg::ADDR_C) ##0 ad_out[7]);
  c_d_read: cover property (settled_read(rtc_pkg::ADDR_D));
endmodule
bind rtc_core rtc_core_props chk (
  .ref_clk(ref_clk), .rst(rst), .ad_in(ad_in), .ad_out(ad_out),
  .ad_oe_n(ad_oe_n), .as_in(as_in), .ds_n_in(ds_n_in), .rw_n_in(rw_n_in),
  .ce_n_in(ce_n_in), .irq_n_out(irq_n_out), .irq_oe_n(irq_oe_n)
);
`default_nettype wire

// file: dv/test_rtc_time_alarm_irq_core.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: host model on the bus, pulled-up interrupt wire
module test_rtc_time_alarm_irq_core;
  localparam int LIMIT = 80000; // run incl. two half-second waits
  logic ref_clk; // 20 MHz clock
  logic rst; // synchronous reset
  logic [7:0] ad_in; // bus lines
  logic [7:0] ad_out; // core read data
  logic ad_oe_n; // core drives when low
  logic as_in; // address strobe
  logic ds_n_in; // read strobe
  logic rw_n_in; // write strobe
  logic ce_n_in; // chip enable
  logic irq_n_out; // open-drain data
  logic irq_oe_n; // open-drain enable
  logic irq_line; // interrupt wire
  int n_fail = 0; // mismatches
  int total_checks = 0; // comparisons
  int cycles = 0; // hang guard
  assign irq_line = irq_oe_n ? 1'b1 : irq_n_out;
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  // low reference rate: one tick each two cycles keeps a second short
  rtc_core #(.REF_HZ(65536)) dut (
    .ref_clk(ref_clk), .rst(rst), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .as_in(as_in), .ds_n_in(ds_n_in),
    .rw_n_in(rw_n_in), .ce_n_in(ce_n_in), .irq_n_out(irq_n_out),
    .irq_oe_n(irq_oe_n));
  host_model host (
    .ref_clk(ref_clk), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
    .as_in(as_in), .ds_n_in(ds_n_in), .rw_n_in(rw_n_in),
    .ce_n_in(ce_n_in));
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // compare one byte
  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // read and compare a byte
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    check8(v, exp, $sformatf("byte %h", a));
  endtask
  // compare the interrupt wire
  task automatic ichk(input logic e);
    check8({7'h00, irq_line}, {7'h00, e}, "irq wire");
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_fail++;
      complete_run();
    end
  end
  // state straight after reset
  task automatic t_reset_state();
    rchk(rtc_pkg::ADDR_B, rtc_pkg::B_RESET);
    rchk(rtc_pkg::ADDR_C, 8'h00);
    ichk(1'b1);
  endtask
  // all time bytes and both ends of the user bytes
  task automatic t_map_access();
    logic [7:0] val [10];
    val = '{8'h12, 8'h34, 8'h56, 8'h07, 8'h11, 8'h05, 8'h03, 8'h28,
      8'h09, 8'h99};
    host.wr(rtc_pkg::ADDR_B, 8'h82);
    for (int i = 0; i < rtc_pkg::TIME_BYTES; i++)
      host.wr(7'(i), val[i]);
    host.wr(rtc_pkg::ADDR_RAM, 8'hA5);
    host.wr(7'h7F, 8'h5A);
    for (int i = 0; i < rtc_pkg::TIME_BYTES; i++)
      rchk(7'(i), val[i]);
    rchk(rtc_pkg::ADDR_RAM, 8'hA5);
    rchk(7'h7F, 8'h5A);
    host.wr(rtc_pkg::ADDR_B, 8'h02);
  endtask
  // read-only places and freeze side effects
  task automatic t_read_only();
    host.wr(rtc_pkg::ADDR_C, 8'hFF);
    host.wr(rtc_pkg::ADDR_D, 8'hFF);
    host.wr(rtc_pkg::ADDR_A, 8'hA0);
    host.wr(rtc_pkg::ADDR_B, 8'h12);
    host.wr(rtc_pkg::ADDR_B, 8'h92);
    rchk(rtc_pkg::ADDR_B, 8'h82);
    rchk(rtc_pkg::ADDR_A, 8'h20);
    rchk(rtc_pkg::ADDR_C, 8'h00);
    rchk(rtc_pkg::ADDR_D, rtc_pkg::D_VALUE);
    host.wr(rtc_pkg::ADDR_B, 8'h02);
  endtask
  // periodic flag without enable, then late enable
  task automatic t_periodic();
    host.wr(rtc_pkg::ADDR_A, 8'h23);
    repeat (40) @(posedge ref_clk);
    host.wr(rtc_pkg::ADDR_A, 8'h20);
    ichk(1'b1);
    host.wr(rtc_pkg::ADDR_B, 8'h42);
    ichk(1'b0);
    rchk(rtc_pkg::ADDR_C, 8'hC0);
    ichk(1'b1);
    rchk(rtc_pkg::ADDR_C, 8'h00);
    host.wr(rtc_pkg::ADDR_B, 8'h02);
  endtask
  // restart the chain, wildcard alarm, first update
  task automatic t_alarm_update();
    int t0;
    host.wr(rtc_pkg::ADDR_B, 8'h82);
    host.wr(rtc_pkg::ADDR_SEC, 8'h59);
    host.wr(rtc_pkg::ADDR_SEC_AL, 8'hC0);
    host.wr(rtc_pkg::ADDR_MIN_AL, 8'hFF);
    host.wr(rtc_pkg::ADDR_HR_AL, 8'hC5);
    host.wr(rtc_pkg::ADDR_A, 8'h60);
    host.wr(rtc_pkg::ADDR_A, 8'h20);
    t0 = cycles;
    host.wr(rtc_pkg::ADDR_B, 8'h32);
    while (irq_line !== 1'b0 && cycles < t0 + 33000)
      @(posedge ref_clk);
    check8({7'h00, ((cycles - t0) inside {[32700:32800]})}, 8'h01,
      "first update time");
    rchk(rtc_pkg::ADDR_SEC, 8'h00);
    rchk(rtc_pkg::ADDR_MIN, 8'h57);
    rchk(rtc_pkg::ADDR_C, 8'hB0);
  endtask
  // binary 12-hour rollover at year end with an exact alarm match
  task automatic t_rollover();
    int t0;
    host.wr(rtc_pkg::ADDR_B, 8'h84);
    host.wr(rtc_pkg::ADDR_SEC, 8'h3B);
    host.wr(rtc_pkg::ADDR_MIN, 8'h3B);
    host.wr(rtc_pkg::ADDR_HR, 8'h8B);
    host.wr(rtc_pkg::ADDR_WDAY, 8'h07);
    host.wr(rtc_pkg::ADDR_MDAY, 8'h1F);
    host.wr(rtc_pkg::ADDR_MON, 8'h0C);
    host.wr(rtc_pkg::ADDR_YEAR, 8'h63);
    host.wr(rtc_pkg::ADDR_SEC_AL, 8'h00);
    host.wr(rtc_pkg::ADDR_MIN_AL, 8'h00);
    host.wr(rtc_pkg::ADDR_HR_AL, 8'h0C);
    host.wr(rtc_pkg::ADDR_A, 8'h60);
    host.wr(rtc_pkg::ADDR_A, 8'h20);
    t0 = cycles;
    host.wr(rtc_pkg::ADDR_B, 8'h24);
    ichk(1'b1);
    while (irq_line !== 1'b0 && cycles < t0 + 33000)
      @(posedge ref_clk);
    check8({7'h00, ((cycles - t0) inside {[32700:32800]})}, 8'h01,
      "second update time");
    rchk(rtc_pkg::ADDR_SEC, 8'h00);
    rchk(rtc_pkg::ADDR_MIN, 8'h00);
    rchk(rtc_pkg::ADDR_HR, 8'h0C);
    rchk(rtc_pkg::ADDR_WDAY, 8'h01);
    rchk(rtc_pkg::ADDR_MDAY, 8'h01);
    rchk(rtc_pkg::ADDR_MON, 8'h01);
    rchk(rtc_pkg::ADDR_YEAR, 8'h00);
    rchk(rtc_pkg::ADDR_C, 8'hB0);
  endtask
  // main sequence
  initial
  begin
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset_state();
    t_map_access();
    t_read_only();
    t_periodic();
    t_alarm_update();
    t_rollover();
    complete_run();
  end
endmodule
`default_nettype wire
